// file: design/hpd_pkg.sv
// Shared constants and types for the headphone detect and charge pump controller
package hpd_pkg;
	// Clock rate and jack sampling base interval
	localparam int CLK_MHZ = 125;
	localparam int SAMPLE_BASE_US = 1000;
	localparam int SAMPLE_BASE_CYCLES = SAMPLE_BASE_US * CLK_MHZ;
	// Jack field widths
	localparam int THR_W = 2;
	localparam int RATE_W = 3;
	localparam int DEB_W = 2;
	localparam int DEB_CNT_W = 5;
	// Threshold code to percent of supply: 84, 88, 92, 96
	localparam logic [6:0] THR_PCT_MIN = 7'h54;
	localparam logic [6:0] THR_PCT_STEP = 7'h04;
	// Debounce measurements are 2 << code
	localparam logic [DEB_CNT_W-1:0] DEB_MIN = 5'h02;
	// Output load status encodings
	localparam logic [1:0] LOAD_NORMAL = 2'h0;
	localparam logic [1:0] LOAD_LINE = 2'h1;
	localparam logic [1:0] LOAD_OPEN = 2'h2;
	// Charge pump tracking modes
	typedef enum logic [1:0] {
		PM_MANUAL = 2'h0,
		PM_GAIN = 2'h1,
		PM_DAC = 2'h2,
		PM_OUT = 2'h3
	} hpd_mode_e;
	// Pump supply states, Gray along off, full rail, half rail
	typedef enum logic [1:0] {
		PS_OFF = 2'b00,
		PS_FULL = 2'b01,
		PS_HALF = 2'b11
	} hpd_pump_e;
	// Pump clock divide exponents: /8 fastest, /128 slowest, 0 stops
	localparam logic [2:0] DIV_EXP_MAX = 3'h3;
	localparam logic [2:0] DIV_EXP_MIN = 3'h7;
	localparam logic [2:0] DIV_EXP_STOP = 3'h0;
	localparam logic [2:0] FSEL_NO_MIN = 3'h5;
	// Attenuation steps (dB below full scale) for demanded level
	localparam logic [6:0] ATT_LVL3 = 7'h06;
	localparam logic [6:0] ATT_LVL2 = 7'h0C;
	localparam logic [6:0] ATT_LVL1 = 7'h18;
	// Boost hold after a demand rise
	localparam int BOOST_HOLD_NS = 1000;
	localparam int BOOST_HOLD_CYCLES = (BOOST_HOLD_NS * CLK_MHZ) / 1000;
	localparam int BOOST_W = 8;
	// Demanded level from attenuation below full scale, 3 is full scale
	function automatic logic [1:0] attLevel(input logic [6:0] att);
		if (att < ATT_LVL3) begin
			return 2'h3;
		end else if (att < ATT_LVL2) begin
			return 2'h2;
		end else if (att < ATT_LVL1) begin
			return 2'h1;
		end
		return 2'h0;
	endfunction
	// Reserved DAC codes fall back to the loudest switching point, 10 dB below full scale
	function automatic logic [6:0] dacThrDb(input logic [5:0] code);
		if (code <= 6'h01) begin
			return 7'h1E;
		end else if (code <= 6'h03) begin
			return 7'h18;
		end else if (code <= 6'h07) begin
			return 7'h12;
		end else if (code <= 6'h0E) begin
			return 7'h0C;
		end
		return 7'h0A;
	endfunction
	function automatic logic outHalf(input logic [5:0] code, input logic [6:0] att);
		logic [6:0] db;
		db = 7'h00;
		case (code)
			6'h00, 6'h01: return 1'b0;
			6'h02: db = 7'h20;
			6'h03: db = 7'h18;
			6'h04: db = 7'h14;
			6'h05: db = 7'h11;
			6'h06: db = 7'h0F;
			6'h07: db = 7'h0D;
			6'h08: db = 7'h0C;
			6'h09: db = 7'h0B;
			6'h0A: db = 7'h0A;
			6'h0B: db = 7'h09;
			default: return 1'b1;
		endcase
		return att > db;
	endfunction
	function automatic logic [2:0] selExp(input logic [2:0] sel);
		case (sel)
			3'h0: return DIV_EXP_MAX;
			3'h1: return 3'h4;
			3'h2: return 3'h5;
			3'h3: return 3'h6;
			default: return DIV_EXP_MIN;
		endcase
	endfunction
endpackage

// file: design/hpd_debounce.sv
// Debounce filter: a new level must repeat on consecutive samples
`timescale 1ns/1ps
module hpd_debounce #(
	parameter int CNT_W = hpd_pkg::DEB_CNT_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Samples
	input wire logic enable,
	input wire logic sampleTick,
	input wire logic sampleLevel,
	input wire logic [CNT_W-1:0] needCount,
	// Result
	output logic stableLevel,
	output logic changed
);
	typedef struct packed {
		logic stable;
		logic [CNT_W-1:0] cnt;
		logic chg;
	} hpd_deb_s;

	hpd_deb_s q, d;

	if (CNT_W < 2) begin : g_chk
		$error("hpd_debounce: CNT_W too small");
	end

	always_comb begin
		d = q;
		d.chg = 1'b0;
		if (!enable) begin
			d.stable = 1'b0;
			d.cnt = '0;
		end else if (sampleTick) begin
			if (sampleLevel == q.stable) begin
				d.cnt = '0;
			end else if (q.cnt + 1'b1 >= needCount) begin
				d.stable = sampleLevel;
				d.cnt = '0;
				d.chg = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign stableLevel = q.stable;
	assign changed = q.chg;
endmodule

// file: design/hpd_pump_clkdiv.sv
// Charge pump clock divider: half period is 2^(exp-1) system clocks
`timescale 1ns/1ps
module hpd_pump_clkdiv (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Control
	input wire logic [2:0] divExp,
	// Output
	output logic pumpClk
);
	typedef struct packed {
		logic [6:0] cnt;
		logic clk;
	} hpd_div_s;

	hpd_div_s q, d;
	logic [6:0] halfCnt;

	always_comb begin
		d = q;
		halfCnt = 7'h01 << (divExp - 3'h1);
		// Exponent 0 stops the clock low
		if (divExp == hpd_pkg::DIV_EXP_STOP) begin
			d.cnt = '0;
			d.clk = 1'b0;
		end else if (q.cnt >= halfCnt - 7'h01) begin
			d.cnt = '0;
			d.clk = ~q.clk;
		end else begin
			d.cnt = q.cnt + 7'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pumpClk = q.clk;
endmodule

// file: design/hpd_ctrl.sv
// Headphone jack detect, load test and charge pump controller
// What this block does
// - Detect enable powers source; low means inserted
// - Threshold field selects 84 to 96 percent
// - Periodic sampling with programmable debounce count
// - Invert bit flips the comparator result
// - Hysteresis only while its enable is set
// - Debounced jack transition raises an interrupt
// - Withdrawal discharges mic bias when both enabled
// - Reinsertion restores mic bias if enabled
// - Stereo test reports mono or stereo status
// - Load test reports line or open per side
// - Pump runs only while its enable is set
// - Mode 00 level follows manual field only
// - Mode 01 level follows amplifier gain
// - Mode 10 level follows DAC envelope
// - Mode 11 combines gain and signal size
// - Modes 10 and 11 choose full/half rail
// - DAC mode threshold codes map to dBFS
// - Output mode codes: never, dBFS, always half
// - Gain tracking boosts pump clock on demand
// - Signal tracking boosts pump clock on demand
// - Tracking clock spans minimum up to /8
`timescale 1ns/1ps
module hpd_ctrl #(
	parameter int SAMPLE_BASE_CYCLES = hpd_pkg::SAMPLE_BASE_CYCLES,
	parameter int BOOST_HOLD_CYCLES = hpd_pkg::BOOST_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Jack detect control
	input wire logic jackDetEnable,
	input wire logic [hpd_pkg::THR_W-1:0] jackThreshold,
	input wire logic [hpd_pkg::RATE_W-1:0] jackRate,
	input wire logic [hpd_pkg::DEB_W-1:0] jackDebounce,
	input wire logic jackCompInvert,
	input wire logic jackHystEnable,
	input wire logic dischargeEnable,
	input wire logic micBiasEnable,
	// Jack analogue side
	input wire logic jackCompHigh,
	output logic currentSourceOn,
	output logic [6:0] thresholdPercent,
	output logic compHystOn,
	// Jack status
	output logic jackInserted,
	output logic jackIrq,
	output logic firstMicBiasOutput,
	output logic micBiasDischarge,
	// Stereo and load tests
	input wire logic stereoTestEnable,
	input wire logic stereoSense,
	output logic stereoTestResult,
	input wire logic lineLoadTestEnable,
	input wire logic [1:0] leftLoadSense,
	input wire logic [1:0] rightLoadSense,
	output logic [1:0] leftPhoneOutLoad,
	output logic [1:0] rightPhoneOutLoad,
	// Charge pump control
	input wire logic pumpEnable,
	input wire logic [1:0] pumpTrackingMode,
	input wire logic [1:0] pumpManualLevel,
	input wire logic [5:0] pumpHalfRailThreshold,
	input wire logic [2:0] pumpClockMinSelect,
	// Tracked quantities
	input wire logic [5:0] ampGain,
	input wire logic [6:0] dacAtten,
	input wire logic [6:0] outAtten,
	// Charge pump outputs
	output logic pumpRun,
	output logic pumpHalfRail,
	output logic [1:0] pumpLevel,
	output logic pumpBoost,
	output logic pumpClk
);
	localparam int RCW = $clog2(SAMPLE_BASE_CYCLES) + 8;

	if (SAMPLE_BASE_CYCLES < 1 || BOOST_HOLD_CYCLES < 1 ||
		BOOST_HOLD_CYCLES >= (1 << hpd_pkg::BOOST_W)) begin : g_chk
		$error("hpd_ctrl: count parameter out of range");
	end

	typedef struct packed {
		logic [RCW-1:0] rateCnt;
		logic tick;
		logic srcOn;
		logic [6:0] thrPct;
		logic hystOn;
		logic biasOn;
		logic discharge;
		logic stereoRes;
		logic [3:0] loadStat;
		hpd_pkg::hpd_pump_e pState;
		logic [1:0] level;
		logic [hpd_pkg::BOOST_W-1:0] boostCnt;
		logic boost;
		logic [2:0] divExp;
	} hpd_state_s;

	hpd_state_s q, d;
	logic sampleInserted;
	logic [hpd_pkg::DEB_CNT_W-1:0] needCount;
	logic [RCW-1:0] rateLimit;
	logic [3:0] loadNext;
	logic [1:0] demand;
	logic wantHalf;
	logic tracking;
	hpd_pkg::hpd_mode_e mode;

	////////////////////////////////////////////////////////////////////////////
	// Jack sampling

	assign sampleInserted = ~(jackCompHigh ^ jackCompInvert);
	assign needCount = hpd_pkg::DEB_MIN << jackDebounce;
	assign rateLimit = RCW'(SAMPLE_BASE_CYCLES) << jackRate;

	hpd_debounce #(
		.CNT_W(hpd_pkg::DEB_CNT_W)
	) u_deb (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.enable(jackDetEnable),
		.sampleTick(q.tick),
		.sampleLevel(sampleInserted),
		.needCount(needCount),
		.stableLevel(jackInserted),
		.changed(jackIrq)
	);

	////////////////////////////////////////////////////////////////////////////
	// Load test, one slice per output

	for (genvar ch = 0; ch < 2; ch++) begin : g_load
		logic [1:0] sense;
		assign sense = (ch == 0) ? leftLoadSense : rightLoadSense;
		// per side line load or open
		assign loadNext[2*ch+:2] = !lineLoadTestEnable ? q.loadStat[2*ch+:2] :
			sense[1] ? hpd_pkg::LOAD_OPEN :
			sense[0] ? hpd_pkg::LOAD_LINE : hpd_pkg::LOAD_NORMAL;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pump demand

	assign mode = hpd_pkg::hpd_mode_e'(pumpTrackingMode);
	assign tracking = pumpEnable && mode != hpd_pkg::PM_MANUAL;

	always_comb begin
		demand = pumpManualLevel;
		wantHalf = 1'b0;
		case (mode)
			hpd_pkg::PM_MANUAL: demand = pumpManualLevel;
			hpd_pkg::PM_GAIN: demand = ampGain[5:4];
			hpd_pkg::PM_DAC: begin
				demand = hpd_pkg::attLevel(dacAtten);
				wantHalf = dacAtten > hpd_pkg::dacThrDb(pumpHalfRailThreshold);
			end
			hpd_pkg::PM_OUT: begin
				demand = (ampGain[5:4] < hpd_pkg::attLevel(outAtten)) ? ampGain[5:4] :
					hpd_pkg::attLevel(outAtten);
				wantHalf = hpd_pkg::outHalf(pumpHalfRailThreshold, outAtten);
			end
			default: demand = pumpManualLevel;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!jackDetEnable || q.rateCnt >= rateLimit - 1'b1) begin
			d.rateCnt = '0;
			d.tick = jackDetEnable;
		end else begin
			d.rateCnt = q.rateCnt + 1'b1;
		end
		d.srcOn = jackDetEnable;
		d.thrPct = hpd_pkg::THR_PCT_MIN + 7'(jackThreshold) * hpd_pkg::THR_PCT_STEP;
		d.hystOn = jackDetEnable && jackHystEnable;
		d.discharge = dischargeEnable && jackDetEnable && !jackInserted;
		d.biasOn = micBiasEnable && !d.discharge;
		// stereo status while enabled, held after
		if (stereoTestEnable) begin
			d.stereoRes = stereoSense;
		end
		d.loadStat = loadNext;

		case (q.pState)
			hpd_pkg::PS_OFF: d.pState = pumpEnable ? hpd_pkg::PS_FULL : hpd_pkg::PS_OFF;
			hpd_pkg::PS_FULL: begin
				if (!pumpEnable) begin
					d.pState = hpd_pkg::PS_OFF;
				end else if (mode[1] && wantHalf) begin
					d.pState = hpd_pkg::PS_HALF;
				end
			end
			hpd_pkg::PS_HALF: begin
				if (!pumpEnable) begin
					d.pState = hpd_pkg::PS_OFF;
				end else if (!mode[1] || !wantHalf) begin
					d.pState = hpd_pkg::PS_FULL;
				end
			end
			default: d.pState = hpd_pkg::PS_OFF;
		endcase
		d.level = pumpEnable ? demand : 2'h0;

		// tracked demand rise (gain or signal mode) boosts clock
		// A rise restarts the hold so bursts keep the clock fast
		if (tracking && demand > q.level) begin
			d.boostCnt = hpd_pkg::BOOST_W'(BOOST_HOLD_CYCLES);
		end else if (!tracking) begin
			d.boostCnt = '0;
		end else if (q.boostCnt != '0) begin
			d.boostCnt = q.boostCnt - 1'b1;
		end
		d.boost = d.boostCnt != '0;

		if (!pumpEnable) begin
			d.divExp = hpd_pkg::DIV_EXP_STOP;
		end else if (!tracking) begin
			d.divExp = hpd_pkg::selExp(pumpClockMinSelect);
		end else if (d.boost) begin
			d.divExp = hpd_pkg::DIV_EXP_MAX;
		end else if (pumpClockMinSelect == hpd_pkg::FSEL_NO_MIN) begin
			d.divExp = hpd_pkg::DIV_EXP_STOP;
		end else begin
			d.divExp = hpd_pkg::selExp(pumpClockMinSelect);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	hpd_pump_clkdiv u_div (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.divExp(q.divExp),
		.pumpClk(pumpClk)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign currentSourceOn = q.srcOn;
	assign thresholdPercent = q.thrPct;
	assign compHystOn = q.hystOn;
	assign firstMicBiasOutput = q.biasOn;
	assign micBiasDischarge = q.discharge;
	assign stereoTestResult = q.stereoRes;
	assign leftPhoneOutLoad = q.loadStat[1:0];
	assign rightPhoneOutLoad = q.loadStat[3:2];
	assign pumpRun = q.pState != hpd_pkg::PS_OFF;
	assign pumpHalfRail = q.pState == hpd_pkg::PS_HALF;
	assign pumpLevel = q.level;
	assign pumpBoost = q.boost;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_src;
		@(posedge sys_clk) disable iff (!rst_b)
		!jackDetEnable |=> !currentSourceOn && !jackInserted;
	endproperty
	a_src: assert property (p_src) else $error("source on while disabled");

	property p_irq;
		@(posedge sys_clk) disable iff (!rst_b)
		jackIrq |-> jackInserted != $past(jackInserted);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without state change");

	property p_dis;
		@(posedge sys_clk) disable iff (!rst_b)
		dischargeEnable && jackDetEnable && !jackInserted |=>
			micBiasDischarge && !firstMicBiasOutput;
	endproperty
	a_dis: assert property (p_dis) else $error("bias not discharged");

	property p_bias;
		@(posedge sys_clk) disable iff (!rst_b)
		jackInserted && micBiasEnable |=> firstMicBiasOutput;
	endproperty
	a_bias: assert property (p_bias) else $error("bias not restored");

	property p_stereo;
		@(posedge sys_clk) disable iff (!rst_b)
		stereoTestEnable |=> stereoTestResult == $past(stereoSense);
	endproperty
	a_stereo: assert property (p_stereo) else $error("stereo status wrong");

	property p_run;
		@(posedge sys_clk) disable iff (!rst_b)
		!pumpEnable [*2] |-> !pumpRun && !pumpHalfRail;
	endproperty
	a_run: assert property (p_run) else $error("pump runs while disabled");

	property p_manual;
		@(posedge sys_clk) disable iff (!rst_b)
		pumpEnable && pumpTrackingMode == 2'h0 |=> pumpLevel == $past(pumpManualLevel);
	endproperty
	a_manual: assert property (p_manual) else $error("manual level ignored");

	property p_fixed;
		@(posedge sys_clk) disable iff (!rst_b)
		!pumpTrackingMode[1] [*2] |-> !pumpHalfRail;
	endproperty
	a_fixed: assert property (p_fixed) else $error("rail moved in fixed mode");

	property p_never;
		@(posedge sys_clk) disable iff (!rst_b)
		(pumpEnable && pumpTrackingMode == 2'h3 && pumpHalfRailThreshold <= 6'h01) [*2]
			|-> pumpRun && !pumpHalfRail;
	endproperty
	a_never: assert property (p_never) else $error("half rail on never code");

	property p_boost;
		@(posedge sys_clk) disable iff (!rst_b)
		pumpBoost |-> q.divExp == hpd_pkg::DIV_EXP_MAX;
	endproperty
	a_boost: assert property (p_boost) else $error("boost not at /8");
endmodule

// file: tb/hpd_jack_model.sv
// Headset socket model: detect pin, stereo and load senses
`timescale 1ns/1ps
module hpd_jack_model (
	// Clock and socket state
	input wire logic sys_clk,
	input wire logic plugged,
	input wire logic normallyClosed,
	input wire logic stereoPlug,
	input wire logic [1:0] leftLoad,
	input wire logic [1:0] rightLoad,
	// Device side
	input wire logic currentSourceOn,
	input wire logic stereoTestEnable,
	input wire logic lineLoadTestEnable,
	output logic jackCompHigh,
	output logic stereoSense,
	output logic [1:0] leftLoadSense,
	output logic [1:0] rightLoadSense
);
	logic junk = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Undriven sense lines float, so they show a changing pattern
	always @(posedge sys_clk) begin
		junk <= ~junk;
	end
	assign jackCompHigh = currentSourceOn ? (plugged ^ ~normallyClosed) : junk;
	assign stereoSense = stereoTestEnable ? stereoPlug : junk;
	assign leftLoadSense = lineLoadTestEnable ? leftLoad : {junk, ~junk};
	assign rightLoadSense = lineLoadTestEnable ? rightLoad : {~junk, junk};
endmodule

// file: tb/hpd_ctrl_test.sv
// Self-checking bench for the jack detect and charge pump controller
`timescale 1ns/1ps
module hpd_ctrl_test;
	logic sysClk, rstB, jackDetEnable, jackCompInvert, jackHystEnable, dischargeEnable;
	logic micBiasEnable, jackCompHigh, currentSourceOn, compHystOn, jackInserted, jackIrq;
	logic firstMicBiasOutput, micBiasDischarge, stereoTestEnable, stereoSense, stereoTestResult;
	logic lineLoadTestEnable, pumpEnable, pumpRun, pumpHalfRail, pumpBoost, pumpClk;
	logic plugged, normallyClosed, stereoPlug;
	logic [1:0] jackThreshold, jackDebounce, leftLoadSense, rightLoadSense, leftLoad, rightLoad;
	logic [1:0] leftPhoneOutLoad, rightPhoneOutLoad, pumpTrackingMode, pumpManualLevel, pumpLevel;
	logic [2:0] jackRate, pumpClockMinSelect;
	logic [5:0] pumpHalfRailThreshold, ampGain;
	logic [6:0] thresholdPercent, dacAtten, outAtten;
	int nErrors = 0;
	int cmpCount = 0;
	localparam int SAMPLE_BASE = 4;
	hpd_ctrl #(.SAMPLE_BASE_CYCLES(SAMPLE_BASE), .BOOST_HOLD_CYCLES(4)) dut_u (.sys_clk(sysClk),
		.rst_b(rstB), .jackDetEnable(jackDetEnable), .jackThreshold(jackThreshold),
		.jackRate(jackRate), .jackDebounce(jackDebounce), .jackCompInvert(jackCompInvert),
		.jackHystEnable(jackHystEnable), .dischargeEnable(dischargeEnable),
		.micBiasEnable(micBiasEnable), .jackCompHigh(jackCompHigh),
		.currentSourceOn(currentSourceOn), .thresholdPercent(thresholdPercent),
		.compHystOn(compHystOn), .jackInserted(jackInserted), .jackIrq(jackIrq),
		.firstMicBiasOutput(firstMicBiasOutput), .micBiasDischarge(micBiasDischarge),
		.stereoTestEnable(stereoTestEnable), .stereoSense(stereoSense),
		.stereoTestResult(stereoTestResult), .lineLoadTestEnable(lineLoadTestEnable),
		.leftLoadSense(leftLoadSense), .rightLoadSense(rightLoadSense),
		.leftPhoneOutLoad(leftPhoneOutLoad), .rightPhoneOutLoad(rightPhoneOutLoad),
		.pumpEnable(pumpEnable), .pumpTrackingMode(pumpTrackingMode),
		.pumpManualLevel(pumpManualLevel), .pumpHalfRailThreshold(pumpHalfRailThreshold),
		.pumpClockMinSelect(pumpClockMinSelect), .ampGain(ampGain), .dacAtten(dacAtten),
		.outAtten(outAtten), .pumpRun(pumpRun), .pumpHalfRail(pumpHalfRail),
		.pumpLevel(pumpLevel), .pumpBoost(pumpBoost), .pumpClk(pumpClk));
	hpd_jack_model jack_u (.sys_clk(sysClk), .plugged(plugged), .normallyClosed(normallyClosed),
		.stereoPlug(stereoPlug), .leftLoad(leftLoad), .rightLoad(rightLoad),
		.currentSourceOn(currentSourceOn), .stereoTestEnable(stereoTestEnable),
		.lineLoadTestEnable(lineLoadTestEnable), .jackCompHigh(jackCompHigh),
		.stereoSense(stereoSense), .leftLoadSense(leftLoadSense), .rightLoadSense(rightLoadSense));
	////////////////////////////////////////////////////////////////////////
	initial begin
		sysClk = 1'b0;
		forever #4 sysClk = ~sysClk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chkBit(input string what, input logic exp, input logic got);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chkVec(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait: a lost event must not hang the run
	task automatic plugCheck(input logic p, input int nDeb, input logic expIns);
		int n;
		int per;
		n = 0;
		per = SAMPLE_BASE << jackRate;
		plugged = p;
		while (jackIrq !== 1'b1) begin
			step(1);
			n++;
			if (n > 200) begin
				chkBit("jackIrq", 1'b1, jackIrq);
				report_and_stop();
			end
		end
		chkBit("irq timing", 1'b1, n >= (nDeb - 1) * per && n <= nDeb * per + 3);
		chkBit("jackInserted", expIns, jackInserted);
		step(1);
		chkBit("irq pulse", 1'b0, jackIrq);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic testJack;
		jackDetEnable = 1'b1;
		jackHystEnable = 1'b1;
		for (int c = 0; c < 4; c++) begin
			jackThreshold = c[1:0];
			step(2);
			chkVec("threshold", {1'b0, 7'h54 + 7'(4 * c)}, {1'b0, thresholdPercent});
		end
		chkBit("source", 1'b1, currentSourceOn);
		chkBit("hyst", 1'b1, compHystOn);
		jackHystEnable = 1'b0;
		step(2);
		chkBit("hyst off", 1'b0, compHystOn);
		plugCheck(1'b1, 2, 1'b1);
		dischargeEnable = 1'b1;
		micBiasEnable = 1'b1;
		jackDebounce = 2'h1;
		step(3);
		plugCheck(1'b0, 4, 1'b0);
		step(2);
		chkBit("discharge", 1'b1, micBiasDischarge);
		chkBit("bias off", 1'b0, firstMicBiasOutput);
		plugCheck(1'b1, 4, 1'b1);
		step(2);
		chkBit("discharge end", 1'b0, micBiasDischarge);
		chkBit("bias back", 1'b1, firstMicBiasOutput);
		jackRate = 3'h1;
		jackCompInvert = 1'b1;
		normallyClosed = 1'b1;
		step(40);
		chkBit("inverted hold", 1'b1, jackInserted);
		plugCheck(1'b0, 4, 1'b0);
		jackDetEnable = 1'b0;
		step(2);
		chkBit("source off", 1'b0, currentSourceOn);
		$display("test jack done");
	endtask
	task automatic testTests;
		// tone ramp is up before the stereo test is enabled
		stereoPlug = 1'b1;
		stereoTestEnable = 1'b1;
		step(2);
		chkBit("stereo", 1'b1, stereoTestResult);
		stereoTestEnable = 1'b0;
		stereoPlug = 1'b0;
		step(3);
		chkBit("stereo hold", 1'b1, stereoTestResult);
		stereoTestEnable = 1'b1;
		step(2);
		chkBit("mono", 1'b0, stereoTestResult);
		stereoTestEnable = 1'b0;
		leftLoad = 2'h1;
		rightLoad = 2'h3;
		lineLoadTestEnable = 1'b1;
		step(2);
		chkVec("left load", {6'h00, hpd_pkg::LOAD_LINE}, {6'h00, leftPhoneOutLoad});
		chkVec("right load", {6'h00, hpd_pkg::LOAD_OPEN}, {6'h00, rightPhoneOutLoad});
		lineLoadTestEnable = 1'b0;
		leftLoad = 2'h0;
		step(2);
		chkVec("left hold", {6'h00, hpd_pkg::LOAD_LINE}, {6'h00, leftPhoneOutLoad});
		lineLoadTestEnable = 1'b1;
		step(2);
		chkVec("left normal", {6'h00, hpd_pkg::LOAD_NORMAL}, {6'h00, leftPhoneOutLoad});
		$display("test stereo and load done");
	endtask
	task automatic pumpSet(input logic [1:0] m, input logic [5:0] thr, input logic [5:0] g,
		input logic [6:0] da, input logic [6:0] oa);
		pumpTrackingMode = m;
		pumpHalfRailThreshold = thr;
		ampGain = g;
		dacAtten = da;
		outAtten = oa;
		step(4);
	endtask
	task automatic boostCheck(input string what);
		int n;
		n = 0;
		while (pumpBoost !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		chkBit(what, 1'b1, pumpBoost);
		if (pumpBoost !== 1'b1) begin
			report_and_stop();
		end
	endtask
	task automatic testPump;
		int edges;
		logic lastClk;
		edges = 0;
		for (int i = 0; i < 40; i++) begin
			step(1);
			edges += int'(pumpClk !== 1'b0);
		end
		chkBit("clk idle", 1'b1, edges == 0 && pumpRun === 1'b0);
		pumpEnable = 1'b1;
		for (int l = 0; l < 4; l++) begin
			pumpManualLevel = l[1:0];
			pumpSet(2'h0, 6'h0C, 6'h00, 7'h50, 7'h50);
			chkVec("manual level", 8'(l), {6'h00, pumpLevel});
			chkBit("manual rail", 1'b0, pumpHalfRail);
		end
		chkBit("run", 1'b1, pumpRun);
		pumpSet(2'h1, 6'h0C, 6'h2A, 7'h50, 7'h50);
		chkVec("gain level", 8'h02, {6'h00, pumpLevel});
		chkBit("gain rail", 1'b0, pumpHalfRail);
		pumpSet(2'h1, 6'h0C, 6'h00, 7'h50, 7'h50);
		ampGain = 6'h3F;
		boostCheck("gain boost");
		pumpSet(2'h2, 6'h10, 6'h3F, 7'h28, 7'h00);
		chkBit("dac half", 1'b1, pumpHalfRail);
		dacAtten = 7'h00;
		boostCheck("dac boost");
		step(4);
		chkBit("dac full", 1'b0, pumpHalfRail);
		chkVec("dac level", 8'h03, {6'h00, pumpLevel});
		pumpSet(2'h3, 6'h0C, 6'h3F, 7'h00, 7'h00);
		chkBit("always half", 1'b1, pumpHalfRail);
		pumpSet(2'h3, 6'h00, 6'h3F, 7'h00, 7'h28);
		chkBit("never half", 1'b0, pumpHalfRail);
		pumpSet(2'h3, 6'h06, 6'h10, 7'h00, 7'h28);
		chkBit("out half", 1'b1, pumpHalfRail);
		pumpSet(2'h3, 6'h06, 6'h10, 7'h00, 7'h00);
		chkVec("combined level", 8'h01, {6'h00, pumpLevel});
		pumpClockMinSelect = 3'h4;
		edges = 0;
		for (int i = 0; i < 300; i++) begin
			lastClk = pumpClk;
			step(1);
			edges += int'(pumpClk !== lastClk);
		end
		// slowest minimum is /128, 64 cycles a half period
		chkBit("clk min rate", 1'b1, edges >= 4 && edges <= 5);
		pumpClockMinSelect = hpd_pkg::FSEL_NO_MIN;
		step(3);
		chkBit("clk no min", 1'b0, pumpClk);
		pumpEnable = 1'b0;
		step(3);
		chkBit("run off", 1'b0, pumpRun);
		$display("test pump done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rstB, jackDetEnable, jackCompInvert, jackHystEnable, dischargeEnable} = '0;
		{micBiasEnable, stereoTestEnable, lineLoadTestEnable, pumpEnable} = '0;
		{plugged, normallyClosed, stereoPlug, leftLoad, rightLoad} = '0;
		{jackThreshold, jackDebounce, jackRate, pumpTrackingMode, pumpManualLevel} = '0;
		{pumpClockMinSelect, pumpHalfRailThreshold, ampGain, dacAtten, outAtten} = '0;
		step(12);
		rstB = 1'b1;
		chkBit("reset inserted", 1'b0, jackInserted);
		chkBit("reset pump", 1'b0, pumpRun);
		testJack();
		testTests();
		testPump();
		report_and_stop();
	end
endmodule
